// File: fcr_pkg.sv
// Constants for the front-end control register bank
package fcr_pkg;
  localparam int FCR_CHANNELS = 128;
  localparam int FCR_SECTORS = 8;
  localparam int FCR_TALLY_W = 24;
  localparam int FCR_REG_W = 8;
  // Register indices on the register port
  localparam logic [1:0] FCR_IDX_RUN_TRIG_CAL = 2'h0;
  localparam logic [1:0] FCR_IDX_MON_POWER = 2'h1;
  localparam logic [1:0] FCR_IDX_PULSE_COUNTER = 2'h2;
  localparam logic [1:0] FCR_IDX_TEST_TRIM = 2'h3;
  // Tally read window, bytes 4..6 low to high
  localparam logic [2:0] FCR_IDX_TALLY_LO = 3'h4;
  localparam logic [2:0] FCR_IDX_TALLY_MID = 3'h5;
  localparam logic [2:0] FCR_IDX_TALLY_HI = 3'h6;
  // Sleep defaults of all registers
  localparam logic [7:0] FCR_RST_REG0 = 8'h00;
  localparam logic [7:0] FCR_RST_REG1 = 8'h00;
  localparam logic [7:0] FCR_RST_REG2 = 8'h00;
  localparam logic [7:0] FCR_RST_REG3 = 8'h00;
  // Register 0 fields
  localparam int FCR_RUN_BIT = 0;
  localparam int FCR_TRIG_LSB = 1;
  localparam int FCR_ONESHOT_POL_BIT = 4;
  localparam int FCR_CALIB_POL_BIT = 5;
  localparam int FCR_CALIB_MODE_LSB = 6;
  // Register 1 fields
  localparam int FCR_MON_SEL_LSB = 0;
  localparam int FCR_PROBE_BIT = 4;
  localparam int FCR_DRV_SAVE_BIT = 5;
  localparam int FCR_CYCLE_LSB = 6;
  // Register 2 fields
  localparam int FCR_SRC_SEL_LSB = 0;
  localparam int FCR_PULSE_LEN_LSB = 4;
  localparam int FCR_BYPASS_BIT = 7;
  // Register 3 fields
  localparam int FCR_TRIM_LSB = 0;
  localparam int FCR_BANDGAP_BIT = 3;
  localparam int FCR_PACKET_BIT = 4;
  localparam logic [7:0] FCR_REG3_USED = 8'h1f;
  // Trigger modes
  localparam logic [2:0] FCR_TRIG_NONE = 3'h0;
  localparam logic [2:0] FCR_TRIG_ONE = 3'h1;
  localparam logic [2:0] FCR_TRIG_FOUR = 3'h2;
  localparam logic [2:0] FCR_TRIG_EIGHT = 3'h3;
  // GEM layout geometry, zero-based channel numbers
  localparam int FCR_GEM_FIRST = 3;
  localparam int FCR_GEM_GROUP = 3;
  localparam int FCR_GEM_STRIDE = 24;
  localparam int FCR_GEM_GROUPS = 5;
  // Tally wrap widths per cycle setting
  localparam int FCR_CYC_W0 = 24;
  localparam int FCR_CYC_W1 = 16;
  localparam int FCR_CYC_W2 = 12;
  localparam int FCR_CYC_W3 = 8;
  localparam logic [7:0] FCR_SECTORS_ALL = 8'hff;
  localparam logic [7:0] FCR_SECTORS_ONE = 8'h01;
  localparam logic [7:0] FCR_SECTORS_FOUR = 8'h0f;
endpackage

// File: fcr_control_regs.sv
// Control register bank with sector trigger mapping and hit tally
//
// Behaviour
// [R1] Register 0: run, trigger, polarities, calibration mode
// [R2] Register 1: monitor select, probe, save, cycle
// [R3] Register 2: tally source, pulse length, bypass
// [R4] Register 3: trim range, bandgap, packet; 7:5 unused
// [R5] Run bit zero keeps device asleep
// [R6] Trigger top bit picks strip or GEM layout
// [R7] Mode 011: eight sectors of sixteen channels
// [R8] Mode 010: four sectors of thirty-two channels
// [R9] GEM layout leaves unbonded edge channels unassigned
// [R10] Save bit disables drivers unused by mode
// [R11] Twenty-four bit hit tally readable by master
// [R12] Tally counts any-hit or one sector
// [R13] Cycle field sets tally counting width
// [R14] Monitor select routes one DAC to output
// [R15] Polarity bits: zero positive, one negative
// [R16] Bypass bit takes hits from digital pads
// [R17] Bandgap enable connects bandgap to pad
// [R18] Packet bit sends fixed data without trigger
// [R19] Trim range field adjusts trim DACs, default zero
// [R20] Pulse length field sets one-shot duration
// [R21] Calibration mode selects calibration circuit operation
// [R22] Four control registers written and read
// [R23] Mode 000 no sectors; 001 one sector
// [R24] GEM: five triples spaced 24, shift three
// [R25] Source 0000 any-hit, 1xxx sector eight
// [R26] Hard reset loads sleep defaults everywhere
// [R27] Writes act next edge; probe bit only drives PROBE_SELECT_OUT
`timescale 1ns/100ps
module fcr_control_regs
  import fcr_pkg::*;
#(
  parameter int CHANNELS = FCR_CHANNELS,
  parameter int TALLY_W = FCR_TALLY_W
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic REG_WR_IN,
  input wire logic [2:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  input wire logic [CHANNELS-1:0] ANALOG_HIT_IN,
  input wire logic [CHANNELS-1:0] DIGITAL_PAD_HIT_IN,
  output logic RUN_NOT_SLEEP_OUT,
  output logic [1:0] CALIB_MODE_OUT,
  output logic CALIB_PULSE_POLARITY_OUT,
  output logic ONESHOT_INPUT_POLARITY_OUT,
  output logic [2:0] ONESHOT_PULSE_LEN_OUT,
  output logic DIGITAL_INPUT_BYPASS_OUT,
  output logic PROBE_SELECT_OUT,
  output logic [3:0] CURRENT_MONITOR_SEL_OUT,
  output logic [3:0] VOLTAGE_MONITOR_SEL_OUT,
  output logic BANDGAP_PAD_ENABLE_OUT,
  output logic FIXED_PACKET_ENABLE_OUT,
  output logic [2:0] TRIM_RANGE_OUT,
  output logic ANY_CHANNEL_HIT_OUT,
  output logic [FCR_SECTORS-1:0] SECTOR_OUT,
  output logic [FCR_SECTORS-1:0] SECTOR_DRIVER_EN_OUT,
  output logic [TALLY_W-1:0] HIT_TALLY_OUT
);

  // ==========================================================
  // Register file
  // ==========================================================
  logic [7:0] ctl0_r;
  logic [7:0] ctl1_r;
  logic [7:0] ctl2_r;
  logic [7:0] ctl3_r;

  // [R26] Sleep defaults on reset
  // [R22] Four writable registers
  // [R27] Write lands next edge
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ctl0_r <= FCR_RST_REG0;
      ctl1_r <= FCR_RST_REG1;
      ctl2_r <= FCR_RST_REG2;
      ctl3_r <= FCR_RST_REG3;
    end else if (REG_WR_IN && !REG_ADDR_IN[2]) begin
      case (REG_ADDR_IN[1:0])
        FCR_IDX_RUN_TRIG_CAL: ctl0_r <= REG_WDATA_IN;
        FCR_IDX_MON_POWER: ctl1_r <= REG_WDATA_IN;
        FCR_IDX_PULSE_COUNTER: ctl2_r <= REG_WDATA_IN;
        // [R4] Unused bits held at zero
        FCR_IDX_TEST_TRIM: ctl3_r <= REG_WDATA_IN & FCR_REG3_USED;
        default: ctl0_r <= ctl0_r;
      endcase
    end
  end

  // ==========================================================
  // Field decode
  // ==========================================================
  // [R1] Register 0 fields
  wire run_not_sleep = ctl0_r[FCR_RUN_BIT];
  wire [2:0] trig_mode = ctl0_r[FCR_TRIG_LSB +: 3];
  wire oneshot_input_polarity = ctl0_r[FCR_ONESHOT_POL_BIT];
  wire calib_pulse_polarity = ctl0_r[FCR_CALIB_POL_BIT];
  wire [1:0] calib_mode = ctl0_r[FCR_CALIB_MODE_LSB +: 2];
  // [R2] Register 1 fields
  wire [3:0] monitor_dac_select = ctl1_r[FCR_MON_SEL_LSB +: 4];
  wire probe_select = ctl1_r[FCR_PROBE_BIT];
  wire sector_driver_save = ctl1_r[FCR_DRV_SAVE_BIT];
  wire [1:0] hit_tally_cycle_len = ctl1_r[FCR_CYCLE_LSB +: 2];
  // [R3] Register 2 fields
  wire [3:0] hit_tally_source_select = ctl2_r[FCR_SRC_SEL_LSB +: 4];
  wire [2:0] oneshot_pulse_len = ctl2_r[FCR_PULSE_LEN_LSB +: 3];
  wire digital_input_bypass = ctl2_r[FCR_BYPASS_BIT];
  // [R4] Register 3 fields
  wire [2:0] trim_range = ctl3_r[FCR_TRIM_LSB +: 3];
  wire bandgap_pad_enable = ctl3_r[FCR_BANDGAP_BIT];
  wire fixed_packet_enable = ctl3_r[FCR_PACKET_BIT];

  // ==========================================================
  // Hit selection and sector mapping
  // ==========================================================
  logic [CHANNELS-1:0] hits;
  // [R16] Digital pads bypass front end
  // [R5] Sleep blanks all hits
  always_comb begin
    hits = digital_input_bypass ? DIGITAL_PAD_HIT_IN : ANALOG_HIT_IN;
    if (!run_not_sleep) begin
      hits = '0;
    end
  end

  // Channel to GEM sector, FCR_SECTORS when unbonded
  function automatic int gem_sector(input int ch);
    int off;
    int grp;
    off = ch - FCR_GEM_FIRST;
    grp = off / FCR_GEM_STRIDE;
    gem_sector = FCR_SECTORS;
    if (off >= 0 && grp < FCR_GEM_GROUPS) begin
      gem_sector = (off % FCR_GEM_STRIDE) / FCR_GEM_GROUP;
    end
  endfunction

  logic [FCR_SECTORS-1:0] strip8;
  logic [FCR_SECTORS-1:0] strip4;
  logic [FCR_SECTORS-1:0] gem;
  genvar s;
  generate
    for (s = 0; s < FCR_SECTORS; s++) begin : g_sector
      logic [CHANNELS-1:0] gem_mask;
      always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
          // [R24] Triples spaced 24 apart
          // [R9] Edge channels excluded
          gem_mask[c] = (gem_sector(c) == s);
        end
      end
      // [R7] Sixteen-channel sectors
      assign strip8[s] = |hits[s*(CHANNELS/8) +: CHANNELS/8];
      // [R8] Thirty-two-channel sectors
      if (s < 4) begin : g_four
        assign strip4[s] = |hits[s*(CHANNELS/4) +: CHANNELS/4];
      end else begin : g_none
        assign strip4[s] = 1'b0;
      end
      assign gem[s] = |(hits & gem_mask);
    end
  endgenerate

  wire any_hit = |hits;
  logic [FCR_SECTORS-1:0] sector_nxt;
  logic [FCR_SECTORS-1:0] needed;
  // [R6] Top bit selects GEM layout
  // [R23] None or single sector
  always_comb begin
    if (trig_mode[2]) begin
      sector_nxt = gem;
      needed = FCR_SECTORS_ALL;
    end else begin
      case (trig_mode)
        FCR_TRIG_ONE: begin
          sector_nxt = {{(FCR_SECTORS-1){1'b0}}, any_hit};
          needed = FCR_SECTORS_ONE;
        end
        FCR_TRIG_FOUR: begin
          sector_nxt = strip4;
          needed = FCR_SECTORS_FOUR;
        end
        FCR_TRIG_EIGHT: begin
          sector_nxt = strip8;
          needed = FCR_SECTORS_ALL;
        end
        default: begin
          sector_nxt = '0;
          needed = '0;
        end
      endcase
    end
  end

  // ==========================================================
  // Hit tally
  // ==========================================================
  logic tally_src;
  // [R12] Any-hit or sector source
  // [R25] Top bit set counts last sector
  always_comb begin
    if (hit_tally_source_select[3]) begin
      tally_src = sector_nxt[FCR_SECTORS-1];
    end else if (hit_tally_source_select == 4'h0) begin
      tally_src = any_hit;
    end else begin
      tally_src = sector_nxt[hit_tally_source_select[2:0] - 3'h1];
    end
  end

  logic [TALLY_W-1:0] wrap_mask;
  // [R13] Cycle sets counting width
  always_comb begin
    case (hit_tally_cycle_len)
      2'h0: wrap_mask = {TALLY_W{1'b1}} >> (TALLY_W - FCR_CYC_W0);
      2'h1: wrap_mask = {TALLY_W{1'b1}} >> (TALLY_W - FCR_CYC_W1);
      2'h2: wrap_mask = {TALLY_W{1'b1}} >> (TALLY_W - FCR_CYC_W2);
      default: wrap_mask = {TALLY_W{1'b1}} >> (TALLY_W - FCR_CYC_W3);
    endcase
  end

  logic [TALLY_W-1:0] tally_r;
  // [R11] Tally increments and wraps
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      tally_r <= '0;
    end else if (tally_src) begin
      tally_r <= (tally_r + TALLY_W'(1)) & wrap_mask;
    end else begin
      tally_r <= tally_r & wrap_mask;
    end
  end

  // ==========================================================
  // Registered outputs
  // ==========================================================
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      SECTOR_OUT <= '0;
      SECTOR_DRIVER_EN_OUT <= FCR_SECTORS_ALL;
      ANY_CHANNEL_HIT_OUT <= 1'b0;
      HIT_TALLY_OUT <= '0;
    end else begin
      SECTOR_OUT <= sector_nxt;
      // [R10] Power save keeps needed drivers
      SECTOR_DRIVER_EN_OUT <= sector_driver_save ? needed : FCR_SECTORS_ALL;
      ANY_CHANNEL_HIT_OUT <= any_hit;
      HIT_TALLY_OUT <= tally_r;
    end
  end

  // Monitor outputs: code 0 selects nothing
  // [R14] One DAC routed at a time
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      CURRENT_MONITOR_SEL_OUT <= '0;
      VOLTAGE_MONITOR_SEL_OUT <= '0;
    end else begin
      CURRENT_MONITOR_SEL_OUT <= monitor_dac_select[3] ? monitor_dac_select : 4'h0;
      VOLTAGE_MONITOR_SEL_OUT <= monitor_dac_select[3] ? 4'h0 : monitor_dac_select;
    end
  end

  // Analog controls mirrored straight from fields
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      RUN_NOT_SLEEP_OUT <= 1'b0;
      CALIB_MODE_OUT <= '0;
      CALIB_PULSE_POLARITY_OUT <= 1'b0;
      ONESHOT_INPUT_POLARITY_OUT <= 1'b0;
      ONESHOT_PULSE_LEN_OUT <= '0;
      DIGITAL_INPUT_BYPASS_OUT <= 1'b0;
      PROBE_SELECT_OUT <= 1'b0;
      BANDGAP_PAD_ENABLE_OUT <= 1'b0;
      FIXED_PACKET_ENABLE_OUT <= 1'b0;
      TRIM_RANGE_OUT <= '0;
    end else begin
      // [R5] Run level
      RUN_NOT_SLEEP_OUT <= run_not_sleep;
      // [R21] Calibration mode
      CALIB_MODE_OUT <= calib_mode;
      // [R15] Polarity selects
      CALIB_PULSE_POLARITY_OUT <= calib_pulse_polarity;
      ONESHOT_INPUT_POLARITY_OUT <= oneshot_input_polarity;
      // [R20] One-shot length
      ONESHOT_PULSE_LEN_OUT <= oneshot_pulse_len;
      DIGITAL_INPUT_BYPASS_OUT <= digital_input_bypass;
      // [R27] Probe bit only drives PROBE_SELECT_OUT
      PROBE_SELECT_OUT <= probe_select;
      // [R17] Bandgap pad switch
      BANDGAP_PAD_ENABLE_OUT <= bandgap_pad_enable;
      // [R18] Fixed packet request to formatter
      FIXED_PACKET_ENABLE_OUT <= fixed_packet_enable;
      // [R19] Trim range
      TRIM_RANGE_OUT <= trim_range;
    end
  end

  // ==========================================================
  // Read port
  // ==========================================================
  // [R11] Tally bytes readable
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      REG_RDATA_OUT <= '0;
    end else begin
      case (REG_ADDR_IN)
        {1'b0, FCR_IDX_RUN_TRIG_CAL}: REG_RDATA_OUT <= ctl0_r;
        {1'b0, FCR_IDX_MON_POWER}: REG_RDATA_OUT <= ctl1_r;
        {1'b0, FCR_IDX_PULSE_COUNTER}: REG_RDATA_OUT <= ctl2_r;
        {1'b0, FCR_IDX_TEST_TRIM}: REG_RDATA_OUT <= ctl3_r;
        FCR_IDX_TALLY_LO: REG_RDATA_OUT <= tally_r[7:0];
        FCR_IDX_TALLY_MID: REG_RDATA_OUT <= tally_r[15:8];
        FCR_IDX_TALLY_HI: REG_RDATA_OUT <= tally_r[23:16];
        default: REG_RDATA_OUT <= 8'h00;
      endcase
    end
  end

endmodule

// File: fcr_control_regs_monitor.sv
// Port checker for the control register bank
`timescale 1ns/100ps
module fcr_control_regs_monitor
  import fcr_pkg::*;
#(
  parameter int TALLY_W = FCR_TALLY_W
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic REG_WR_IN,
  input wire logic [2:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic RUN_NOT_SLEEP_OUT,
  input wire logic [1:0] CALIB_MODE_OUT,
  input wire logic CALIB_PULSE_POLARITY_OUT,
  input wire logic ONESHOT_INPUT_POLARITY_OUT,
  input wire logic [2:0] ONESHOT_PULSE_LEN_OUT,
  input wire logic DIGITAL_INPUT_BYPASS_OUT,
  input wire logic PROBE_SELECT_OUT,
  input wire logic [3:0] CURRENT_MONITOR_SEL_OUT,
  input wire logic [3:0] VOLTAGE_MONITOR_SEL_OUT,
  input wire logic BANDGAP_PAD_ENABLE_OUT,
  input wire logic FIXED_PACKET_ENABLE_OUT,
  input wire logic [2:0] TRIM_RANGE_OUT,
  input wire logic ANY_CHANNEL_HIT_OUT,
  input wire logic [FCR_SECTORS-1:0] SECTOR_OUT,
  input wire logic [FCR_SECTORS-1:0] SECTOR_DRIVER_EN_OUT,
  input wire logic [TALLY_W-1:0] HIT_TALLY_OUT
);
  // ==========
  // Write decode and assertions
  wire [3:0] ws = REG_WR_IN && !REG_ADDR_IN[2] ? 4'h1 << REG_ADDR_IN[1:0] : 4'h0;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  AST_REG0_FIELDS:
  assert property (ws[0] ##1 !ws[0] |=> {CALIB_MODE_OUT, CALIB_PULSE_POLARITY_OUT,
    ONESHOT_INPUT_POLARITY_OUT, RUN_NOT_SLEEP_OUT} == {$past(REG_WDATA_IN[7:4], 2),
    $past(REG_WDATA_IN[0], 2)}) else $error("register 0 fields wrong");
  AST_REG1_FIELDS:
  assert property (ws[1] ##1 !ws[1] |=> {PROBE_SELECT_OUT, CURRENT_MONITOR_SEL_OUT |
    VOLTAGE_MONITOR_SEL_OUT} == $past(REG_WDATA_IN[4:0], 2)) else $error("register 1 wrong");
  AST_REG2_FIELDS:
  assert property (ws[2] ##1 !ws[2] |=> {DIGITAL_INPUT_BYPASS_OUT, ONESHOT_PULSE_LEN_OUT}
    == $past(REG_WDATA_IN[7:4], 2)) else $error("register 2 fields wrong");
  AST_REG3_FIELDS:
  assert property (ws[3] ##1 !ws[3] |=> {FIXED_PACKET_ENABLE_OUT, BANDGAP_PAD_ENABLE_OUT,
    TRIM_RANGE_OUT} == $past(REG_WDATA_IN[4:0], 2)) else $error("register 3 fields wrong");
  AST_REG3_SPARE_READ:
  assert property ($past(REG_ADDR_IN) == 3'h3 |-> REG_RDATA_OUT[7:5] == 3'h0)
    else $error("register 3 spare bits read nonzero");
  AST_UNMAPPED_READ:
  assert property ($past(REG_ADDR_IN) == 3'h7 |-> REG_RDATA_OUT == 8'h00)
    else $error("unmapped index read nonzero");
  AST_MONITOR_SPLIT:
  assert property ((CURRENT_MONITOR_SEL_OUT == 4'h0 || CURRENT_MONITOR_SEL_OUT[3])
    && !VOLTAGE_MONITOR_SEL_OUT[3]) else $error("monitor routed to wrong output");
  AST_SLEEP_IDLE:
  assert property (!RUN_NOT_SLEEP_OUT |-> SECTOR_OUT == 8'h00 && !ANY_CHANNEL_HIT_OUT)
    else $error("hits seen while asleep");
  AST_DRIVER_SET:
  assert property (SECTOR_DRIVER_EN_OUT inside {8'h00, 8'h01, 8'h0f, 8'hff})
    else $error("driver enable pattern illegal");
  AST_SECTOR_NEEDS_HIT:
  assert property (SECTOR_OUT != 8'h00 |-> ANY_CHANNEL_HIT_OUT)
    else $error("sector flag without any hit");
  AST_TALLY_HOLD:
  assert property (!$past(RUN_NOT_SLEEP_OUT) && !$past(REG_WR_IN) && !$past(REG_WR_IN, 2)
    && !$past(REG_WR_IN, 3) |-> $stable(HIT_TALLY_OUT)) else $error("tally moved asleep");
endmodule

// File: fcr_master_model.sv
// Register port master standing in for the serial control unit
`timescale 1ns/100ps
module fcr_master_model (
  input wire logic clk_in,
  output logic wr_out,
  output logic [2:0] addr_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in
);
  initial begin
    wr_out = 1'b0;
    addr_out = 3'h0;
    wdata_out = 8'h00;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in) #1;
    wr_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(posedge clk_in) #1;
    wr_out = 1'b0;
    // Stale data inverted so it is never mistaken for valid
    wdata_out = ~d;
  endtask
  // read data one edge after index
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in) #1;
    addr_out = a;
    @(posedge clk_in) #1;
    d = rdata_in;
  endtask
endmodule

// File: tb_fcr_control_regs.sv
// Self-checking bench for the control register bank
`timescale 1ns/100ps
module tb_fcr_control_regs;
  import fcr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr, run, pol_c, pol_o, byp, probe, bg, pkt, anyh;
  logic [2:0] addr, plen, trim;
  logic [7:0] wdata, rdata, sec, drv;
  logic [127:0] ahit = '0;
  logic [127:0] dhit = '0;
  logic [1:0] cmode;
  logic [3:0] cur, volt;
  logic [23:0] tally;
  int n_mismatch = 0;
  int n_checks = 0;
  initial begin
    forever #4 clk = ~clk;
  end
  fcr_control_regs fcr_control_regs_i (.CLK_IN(clk), .SYS_RST_IN(rst), .REG_WR_IN(wr),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .ANALOG_HIT_IN(ahit),
    .DIGITAL_PAD_HIT_IN(dhit), .RUN_NOT_SLEEP_OUT(run), .CALIB_MODE_OUT(cmode),
    .CALIB_PULSE_POLARITY_OUT(pol_c), .ONESHOT_INPUT_POLARITY_OUT(pol_o),
    .ONESHOT_PULSE_LEN_OUT(plen), .DIGITAL_INPUT_BYPASS_OUT(byp), .PROBE_SELECT_OUT(probe),
    .CURRENT_MONITOR_SEL_OUT(cur), .VOLTAGE_MONITOR_SEL_OUT(volt),
    .BANDGAP_PAD_ENABLE_OUT(bg), .FIXED_PACKET_ENABLE_OUT(pkt), .TRIM_RANGE_OUT(trim),
    .ANY_CHANNEL_HIT_OUT(anyh), .SECTOR_OUT(sec), .SECTOR_DRIVER_EN_OUT(drv),
    .HIT_TALLY_OUT(tally));
  fcr_master_model fcr_master_model_i (.clk_in(clk), .wr_out(wr), .addr_out(addr),
    .wdata_out(wdata), .rdata_in(rdata));
  // ==========
  // Shared tasks
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic do_reset;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
  endtask
  task automatic prog(input logic [2:0] a, input logic [7:0] d);
    fcr_master_model_i.wr(a, d);
    @(posedge clk) #1;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    fcr_master_model_i.rd(a, d);
    chk("readback", exp, d);
  endtask
  task automatic pulse(input int ch, input int n, input bit dig);
    @(posedge clk) #1;
    if (dig) dhit[ch] = 1'b1;
    else ahit[ch] = 1'b1;
    repeat (n) @(posedge clk);
    #1;
    ahit = '0;
    dhit = '0;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    for (int a = 0; a < 4; a++) rdchk(a[2:0], 8'h00);
    chk("drivers", 24'hff, drv);
    chk("fields", 24'h0, {cmode, pol_c, pol_o, run, probe, cur, volt, byp, plen, pkt, bg, trim});
  endtask
  task automatic t_fields;
    logic [7:0] p;
    logic [3:0] m;
    for (int i = 0; i < 2; i++) begin
      p = i ? 8'h5a : 8'ha5;
      m = p[3:0];
      for (int a = 0; a < 4; a++) prog(a[2:0], p);
      for (int a = 0; a < 4; a++) rdchk(a[2:0], a == 3 ? p & FCR_REG3_USED : p);
      chk("fields", {p[7:4], p[0], p[4], p[3] ? m : 4'h0, p[3] ? 4'h0 : m, p[7:4], p[4:0]},
        {cmode, pol_c, pol_o, run, probe, cur, volt, byp, plen, pkt, bg, trim});
    end
    prog(3'h4, 8'hff);
    rdchk(3'h4, 8'h00);
    rdchk(3'h7, 8'h00);
  endtask
  task automatic t_sectors;
    int md[15] = '{3, 3, 3, 2, 2, 2, 1, 0, 4, 4, 4, 4, 4, 4, 7};
    int ix[15] = '{19, 127, 15, 31, 32, 127, 77, 77, 3, 6, 27, 99, 122, 2, 123};
    logic [7:0] ex[15] = '{8'h02, 8'h80, 8'h01, 8'h01, 8'h02, 8'h08, 8'h01, 8'h00,
      8'h01, 8'h02, 8'h01, 8'h01, 8'h80, 8'h00, 8'h00};
    for (int i = 0; i < 15; i++) begin
      prog(3'h0, {4'h0, md[i][2:0], 1'b1});
      pulse(ix[i], 1, 1'b0);
      // Sector flags stand only the one cycle after the hit edge
      chk("sector", ex[i], sec);
    end
  endtask
  task automatic t_bypass;
    prog(3'h0, 8'h07);
    pulse(19, 1, 1'b1);
    chk("pad ignored", 24'h0, {anyh, sec});
    prog(3'h2, 8'h80);
    pulse(19, 1, 1'b1);
    chk("pad taken", 24'h102, {anyh, sec});
    pulse(19, 1, 1'b0);
    chk("front end off", 24'h0, {anyh, sec});
  endtask
  task automatic t_drivers;
    logic [7:0] ex[5] = '{8'h00, 8'h01, 8'h0f, 8'hff, 8'hff};
    prog(3'h1, 8'h20);
    for (int m = 0; m < 5; m++) begin
      prog(3'h0, {4'h0, m[2:0], 1'b1});
      chk("drivers", ex[m], drv);
    end
    prog(3'h1, 8'h00);
    chk("drivers", 24'hff, drv);
  endtask
  task automatic tally_after(input int ch, input int n, input logic [23:0] exp);
    pulse(ch, n, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk("tally", exp, tally);
  endtask
  task automatic t_tally;
    prog(3'h0, 8'h07);
    prog(3'h1, 8'hc0);
    prog(3'h2, 8'h00);
    tally_after(5, 10, 24'd10);
    tally_after(5, 250, 24'd4);
    prog(3'h2, 8'h02);
    tally_after(19, 5, 24'd9);
    tally_after(0, 5, 24'd9);
    prog(3'h2, 8'h08);
    tally_after(120, 3, 24'd12);
    rdchk(3'h4, 8'h0c);
    rdchk(3'h5, 8'h00);
    rdchk(3'h6, 8'h00);
    prog(3'h0, 8'h06);
    pulse(120, 3, 1'b0);
    chk("asleep sectors", 24'h0, sec);
    tally_after(120, 3, 24'd12);
  endtask
  // ==========
  // Sequence and watchdog
  initial begin
    do_reset();
    t_reset();
    t_fields();
    do_reset();
    t_reset();
    t_sectors();
    t_bypass();
    t_drivers();
    do_reset();
    t_tally();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("[ERR] run length exp finish got hang");
    test_done();
  end
endmodule
bind fcr_control_regs fcr_control_regs_monitor #(.TALLY_W(TALLY_W)) fcr_control_regs_monitor_i (
  .CLK_IN, .SYS_RST_IN, .REG_WR_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_RDATA_OUT,
  .RUN_NOT_SLEEP_OUT, .CALIB_MODE_OUT, .CALIB_PULSE_POLARITY_OUT, .ONESHOT_INPUT_POLARITY_OUT,
  .ONESHOT_PULSE_LEN_OUT, .DIGITAL_INPUT_BYPASS_OUT, .PROBE_SELECT_OUT,
  .CURRENT_MONITOR_SEL_OUT, .VOLTAGE_MONITOR_SEL_OUT, .BANDGAP_PAD_ENABLE_OUT,
  .FIXED_PACKET_ENABLE_OUT, .TRIM_RANGE_OUT, .ANY_CHANNEL_HIT_OUT, .SECTOR_OUT,
  .SECTOR_DRIVER_EN_OUT, .HIT_TALLY_OUT);
